// file: src/tsd_detector.sv
// Purpose: transient shake detector with high-pass filter, threshold, debounce and interrupt
// Assumes: sample_valid pulses once per output sample; register port never waits
// Notes: cfg, threshold and debounce registers lock while the detector is active; irq enable stays writable
`timescale 1ns/1ps
module tsd_detector (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic sample_valid,
  input wire logic signed [tsd_pkg::SMP_W-1:0] sample_x,
  input wire logic signed [tsd_pkg::SMP_W-1:0] sample_y,
  input wire logic signed [tsd_pkg::SMP_W-1:0] sample_z,
  input wire logic [tsd_pkg::REG_AW-1:0] reg_addr,
  input wire logic [tsd_pkg::REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [tsd_pkg::REG_DW-1:0] reg_rdata,
  output logic irq
);
  tsd_pkg::tsd_mode_t mode_r;
  logic [tsd_pkg::CFG_W-1:0] cfg_r;
  logic [tsd_pkg::REG_DW-1:0] thr_r;
  logic [tsd_pkg::REG_DW-1:0] dbnc_r;
  logic [tsd_pkg::REG_DW-1:0] cnt_r;
  logic [tsd_pkg::REG_DW-1:0] cnt_nxt;
  logic [tsd_pkg::REG_DW-1:0] cnt_inc;
  logic live_r;
  logic live_nxt;
  logic evt_flag_r;
  logic evt_flag_nxt;
  logic [tsd_pkg::NAXIS-1:0] evt_axes_r;
  logic [tsd_pkg::NAXIS-1:0] evt_axes_nxt;
  logic trig_r;
  logic [tsd_pkg::IRQ_W-1:0] irq_en_r;
  logic [tsd_pkg::REG_DW-1:0] rdata_r;

  wire act = (mode_r == tsd_pkg::TSD_ACTIVE);
  wire step = sample_valid && act;
  wire filter_bypass = cfg_r[tsd_pkg::CFG_BYPASS];
  wire x_axis_event_enable = cfg_r[tsd_pkg::CFG_AXIS_LSB];
  wire y_axis_event_enable = cfg_r[tsd_pkg::CFG_AXIS_LSB + 1];
  wire z_axis_event_enable = cfg_r[tsd_pkg::CFG_AXIS_LSB + 2];
  wire hold = cfg_r[tsd_pkg::CFG_HOLD];
  wire count_down = cfg_r[tsd_pkg::CFG_COUNT_DOWN];
  wire [tsd_pkg::NAXIS-1:0] axis_en = {z_axis_event_enable, y_axis_event_enable, x_axis_event_enable};

  // register decode
  wire wr_ctrl = reg_wr && (reg_addr == tsd_pkg::ADDR_CTRL);
  wire cfg_open = reg_wr && !act; // [R10]
  wire wr_cfg = cfg_open && (reg_addr == tsd_pkg::ADDR_CFG);
  wire wr_thr = cfg_open && (reg_addr == tsd_pkg::ADDR_THR);
  wire wr_dbnc = cfg_open && (reg_addr == tsd_pkg::ADDR_DBNC);
  wire wr_irq_clr = reg_wr && (reg_addr == tsd_pkg::ADDR_IRQ_CLR);
  wire wr_irq_en = reg_wr && (reg_addr == tsd_pkg::ADDR_IRQ_EN);
  wire rd_evt = reg_rd && (reg_addr == tsd_pkg::ADDR_EVT);

  // per-axis filter, magnitude and threshold compare
  logic signed [tsd_pkg::SMP_W-1:0] smp [tsd_pkg::NAXIS];
  logic [tsd_pkg::FLT_W-1:0] raw_mag [tsd_pkg::NAXIS];
  logic [tsd_pkg::FLT_W-1:0] sel_mag [tsd_pkg::NAXIS];
  logic [tsd_pkg::NAXIS-1:0] over;
  assign smp[0] = sample_x;
  assign smp[1] = sample_y;
  assign smp[2] = sample_z;
  wire [tsd_pkg::FLT_W-1:0] thr_ext = tsd_pkg::FLT_W'({thr_r, {tsd_pkg::THR_SHIFT{1'b0}}});

  genvar g;
  generate
    for (g = 0; g < tsd_pkg::NAXIS; g++) begin : g_axis
      logic signed [tsd_pkg::FLT_W-1:0] avg_r;
      wire signed [tsd_pkg::FLT_W-1:0] raw = {{(tsd_pkg::FLT_W - tsd_pkg::SMP_W){smp[g][tsd_pkg::SMP_W-1]}}, smp[g]};
      wire signed [tsd_pkg::FLT_W-1:0] hp = raw - avg_r;
      wire signed [tsd_pkg::FLT_W-1:0] avg_nxt = avg_r + (hp >>> tsd_pkg::HPF_SHIFT);
      wire signed [tsd_pkg::FLT_W-1:0] sel = filter_bypass ? raw : hp; // [R1]
      assign raw_mag[g] = raw[tsd_pkg::FLT_W-1] ? -raw : raw;
      assign sel_mag[g] = sel[tsd_pkg::FLT_W-1] ? -sel : sel;
      assign over[g] = axis_en[g] && (sel_mag[g] >= thr_ext); // [R2] [R4]
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          avg_r <= '0;
        end else if (step) begin
          avg_r <= avg_nxt;
        end
      end
    end
  endgenerate

  wire cond = |over;

  // debounce counter
  assign cnt_inc = (cnt_r == tsd_pkg::CNT_MAX) ? cnt_r : cnt_r + 8'h01; // [R11]
  assign live_nxt = cond && (cnt_inc > dbnc_r); // [R3] [R11]
  assign cnt_nxt = cond ? cnt_inc :
                   (count_down ? ((cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00) : // [R8]
                   8'h00); // [R9]

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
      live_r <= 1'b0;
    end else if (!act) begin
      cnt_r <= '0;
      live_r <= 1'b0;
    end else if (step) begin
      cnt_r <= cnt_nxt;
      live_r <= live_nxt;
    end
  end

  // event status: held until read, or following the live event
  always_comb begin
    evt_flag_nxt = evt_flag_r;
    evt_axes_nxt = evt_axes_r;
    if (hold) begin
      if (step && live_nxt) begin
        evt_flag_nxt = 1'b1; // [R5]
        evt_axes_nxt = evt_axes_r | over;
      end else if (rd_evt) begin
        evt_flag_nxt = 1'b0; // [R5]
        evt_axes_nxt = '0;
      end
    end else if (step) begin
      evt_flag_nxt = live_nxt; // [R6]
      if (live_nxt) begin
        evt_axes_nxt = over; // [R7]
      end
    end else if (!act) begin
      evt_flag_nxt = 1'b0; // [R6]
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      evt_flag_r <= 1'b0;
      evt_axes_r <= '0;
    end else begin
      evt_flag_r <= evt_flag_nxt;
      evt_axes_r <= evt_axes_nxt;
    end
  end

  // threshold crossing sticky bit; a new crossing beats a clear
  wire trig_set = step && cond;
  wire trig_clr = wr_irq_clr && reg_wdata[tsd_pkg::IRQ_TRIG];
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      trig_r <= 1'b0;
    end else if (trig_set) begin
      trig_r <= 1'b1;
    end else if (trig_clr) begin
      trig_r <= 1'b0;
    end
  end

  wire [tsd_pkg::IRQ_W-1:0] irq_stat = {trig_r, evt_flag_r};
  assign irq = |(irq_stat & irq_en_r); // [R5] [R6]

  // configuration and mode registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mode_r <= tsd_pkg::TSD_STANDBY;
    end else if (wr_ctrl) begin
      mode_r <= reg_wdata[tsd_pkg::CTRL_ACTIVE] ? tsd_pkg::TSD_ACTIVE : tsd_pkg::TSD_STANDBY; // [R10]
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_r <= tsd_pkg::CFG_RST;
      thr_r <= tsd_pkg::THR_RST;
      dbnc_r <= tsd_pkg::DBNC_RST;
      irq_en_r <= tsd_pkg::IRQ_EN_RST;
    end else begin
      if (wr_cfg) begin
        cfg_r <= reg_wdata[tsd_pkg::CFG_W-1:0];
      end
      if (wr_thr) begin
        thr_r <= reg_wdata;
      end
      if (wr_dbnc) begin
        dbnc_r <= reg_wdata;
      end
      if (wr_irq_en) begin
        irq_en_r <= reg_wdata[tsd_pkg::IRQ_W-1:0];
      end
    end
  end

  // read mux; unmapped and write-only addresses read zero
  logic [tsd_pkg::REG_DW-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    case (reg_addr)
      tsd_pkg::ADDR_CTRL: rd_mux = tsd_pkg::REG_DW'(act);
      tsd_pkg::ADDR_CFG: rd_mux = tsd_pkg::REG_DW'(cfg_r);
      tsd_pkg::ADDR_THR: rd_mux = thr_r;
      tsd_pkg::ADDR_DBNC: rd_mux = dbnc_r;
      tsd_pkg::ADDR_EVT: rd_mux = {evt_flag_r, 4'h0, evt_axes_r};
      tsd_pkg::ADDR_IRQ_STAT: rd_mux = tsd_pkg::REG_DW'(irq_stat);
      tsd_pkg::ADDR_IRQ_EN: rd_mux = tsd_pkg::REG_DW'(irq_en_r);
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= reg_rd ? rd_mux : '0;
    end
  end
  assign reg_rdata = rdata_r;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  AST_BYPASS_RAW: assert property ( // [R1]
    (step && filter_bypass && x_axis_event_enable && raw_mag[0] >= thr_ext) |-> cond)
    else $error("bypass did not use raw sample");
  AST_BELOW_THR: assert property ( // [R2]
    (step && sel_mag[0] < thr_ext && sel_mag[1] < thr_ext && sel_mag[2] < thr_ext) |=> !live_r)
    else $error("event from sub-threshold sample");
  AST_DEBOUNCE: assert property ( // [R3]
    $rose(live_r) |-> ($past(cnt_r) >= $past(dbnc_r)) && $past(cond))
    else $error("event before debounce elapsed");
  AST_AXIS_EN: assert property ( // [R4]
    (step && !x_axis_event_enable && !over[1] && !over[2]) |=> !live_r && (!trig_r || $past(trig_r)))
    else $error("disabled axes triggered");
  AST_HOLD: assert property ( // [R5]
    (hold && evt_flag_r && !rd_evt) |=> evt_flag_r)
    else $error("held event dropped without read");
  AST_LIVE_IRQ: assert property ( // [R6]
    (act && !hold) |-> (evt_flag_r == live_r))
    else $error("live event flag diverged");
  AST_RECENT: assert property ( // [R7]
    (step && !hold && live_nxt) |=> (evt_axes_r == $past(over)))
    else $error("status not most recent event");
  AST_COUNT_DOWN: assert property ( // [R8]
    (step && count_down && !cond && cnt_r != 8'h00) |=> (cnt_r == $past(cnt_r) - 8'h01))
    else $error("counter not decremented");
  AST_CLEAR: assert property ( // [R9]
    (step && !count_down && !cond) |=> (cnt_r == 8'h00))
    else $error("counter not cleared");
  AST_CFG_LOCK: assert property ( // [R10]
    act |=> $stable(cfg_r) && $stable(thr_r) && $stable(dbnc_r))
    else $error("config changed while active");
  AST_COUNT_UP: assert property ( // [R11]
    (step && cond && cnt_r != tsd_pkg::CNT_MAX) |=> (cnt_r == $past(cnt_r) + 8'h01))
    else $error("counter did not advance");
  AST_CNT_SAT: assert property ( // [R11]
    (step && cond && cnt_r == tsd_pkg::CNT_MAX) |=> (cnt_r == tsd_pkg::CNT_MAX))
    else $error("counter wrapped at its ceiling");
  AST_CNT_FLOOR: assert property ( // [R8]
    (step && count_down && !cond && cnt_r == 8'h00) |=> (cnt_r == 8'h00))
    else $error("counter wrapped below zero");
  AST_IDLE_HOLDS: assert property ( // [R11]
    (act && !sample_valid) |=> $stable(cnt_r) && $stable(live_r))
    else $error("counter moved without a sample");
  AST_STANDBY_IDLE: assert property ( // [R11]
    !act |=> (cnt_r == 8'h00) && !live_r)
    else $error("counter kept in standby");
  AST_STANDBY_FLAG: assert property ( // [R6]
    (!act && !hold) |=> !evt_flag_r)
    else $error("live event flag kept in standby");
  AST_LIVE_DROP: assert property ( // [R6]
    (step && !cond) |=> !live_r)
    else $error("live event outlasted its condition");
  AST_DBNC_NO_EARLY: assert property ( // [R3]
    (step && cond && cnt_r < dbnc_r) |=> !live_r)
    else $error("event fired below debounce count");
  AST_LIVE_FIRE: assert property ( // [R3]
    (step && cond && cnt_r >= dbnc_r && dbnc_r != tsd_pkg::CNT_MAX) |=> live_r)
    else $error("event missed after debounce");
  AST_LIVE_CNT: assert property ( // [R3]
    live_r |-> (cnt_r > dbnc_r))
    else $error("live event with short count");
  AST_HOLD_SET: assert property ( // [R5]
    (hold && step && live_nxt) |=> evt_flag_r)
    else $error("held event not flagged");
  AST_HOLD_AXES: assert property ( // [R5]
    (hold && step && live_nxt) |=> ((evt_axes_r & $past(over)) == $past(over)))
    else $error("held axes lost a new event");
  AST_HOLD_CLEAR: assert property ( // [R5]
    (hold && rd_evt && !(step && live_nxt)) |=> !evt_flag_r && (evt_axes_r == '0))
    else $error("held event not cleared by read");
  AST_RECENT_KEEP: assert property ( // [R7]
    (!hold && !(step && live_nxt)) |=> $stable(evt_axes_r))
    else $error("live axes changed without event");
  AST_TRIG_SET: assert property ( // [R2]
    (step && cond) |=> trig_r)
    else $error("crossing not recorded");
  AST_TRIG_KEEP: assert property ( // [R2]
    (trig_r && !trig_clr) |=> trig_r)
    else $error("crossing bit lost without clear");
  AST_TRIG_CLEAR: assert property ( // [R2]
    (trig_clr && !trig_set) |=> !trig_r)
    else $error("crossing bit not cleared");
  AST_IRQ_EVT: assert property ( // [R5]
    (evt_flag_r && irq_en_r[tsd_pkg::IRQ_EVT]) |-> irq)
    else $error("enabled event without interrupt");
  AST_IRQ_OFF: assert property ( // [R6]
    (irq_en_r == '0) |-> !irq)
    else $error("interrupt with all sources masked");
  AST_BYPASS_HP: assert property ( // [R1]
    (step && !filter_bypass) |-> (g_axis[0].sel == g_axis[0].hp))
    else $error("filtered sample not used");
  AST_AVG_KEEP: assert property ( // [R1]
    !act |=> $stable(g_axis[0].avg_r))
    else $error("filter state moved in standby");

  // register port and mode control
  AST_MODE_WRITE: assert property ( // [R10]
    wr_ctrl |=> (act == $past(reg_wdata[tsd_pkg::CTRL_ACTIVE])))
    else $error("mode write not applied");
  AST_MODE_KEEP: assert property ( // [R10]
    !wr_ctrl |=> $stable(mode_r))
    else $error("mode changed without write");
  AST_CFG_WRITE: assert property ( // [R10]
    wr_cfg |=> (cfg_r == $past(reg_wdata[tsd_pkg::CFG_W-1:0])))
    else $error("standby config write lost");
  AST_THR_WRITE: assert property ( // [R10]
    wr_thr |=> (thr_r == $past(reg_wdata)))
    else $error("standby threshold write lost");
  AST_DBNC_WRITE: assert property ( // [R10]
    wr_dbnc |=> (dbnc_r == $past(reg_wdata)))
    else $error("standby debounce write lost");
  AST_RDATA_IDLE: assert property ( // [R10]
    !reg_rd |=> (reg_rdata == '0))
    else $error("read data outside its cycle");
  AST_RD_MODE: assert property ( // [R10]
    (reg_rd && reg_addr == tsd_pkg::ADDR_CTRL) |=> (reg_rdata == tsd_pkg::REG_DW'($past(act))))
    else $error("mode read back wrong");
  AST_EVT_READ: assert property ( // [R5]
    rd_evt |=> (reg_rdata[tsd_pkg::EVT_ACTIVE] == $past(evt_flag_r)) &&
      (reg_rdata[tsd_pkg::NAXIS-1:0] == $past(evt_axes_r)))
    else $error("event register read back wrong");
  AST_STAT_READ: assert property ( // [R5]
    (reg_rd && reg_addr == tsd_pkg::ADDR_IRQ_STAT) |=> (reg_rdata == tsd_pkg::REG_DW'($past(irq_stat))))
    else $error("status read back wrong");

  COV_HOLD_READ: cover property (hold && evt_flag_r ##1 rd_evt ##1 !evt_flag_r);
  COV_LIVE_EVT: cover property (!hold && act && $rose(live_r) ##[1:20] $fell(live_r));
  COV_DECREMENT: cover property (step && count_down && !cond && cnt_r > 8'h01);
  COV_AXIS_MASKED: cover property (step && !x_axis_event_enable && raw_mag[0] >= thr_ext);
  COV_TRIG_CLEAR: cover property (trig_r && trig_clr ##1 !trig_r);
endmodule // tsd_detector

// file: include/tsd_pkg.sv
// Purpose: constants and types of the transient shake detector
// Assumes: 12-bit signed samples per axis, 8-bit register port
// Notes: register map and field positions live here only
//
// Functional notes
// R1 - with filter bypass set, raw samples feed the detector instead of filtered ones.
// R2 - magnitudes below the threshold never count towards an event.
// R3 - event and interrupt only when the condition outlasts the debounce value; an enabled IRQ_TRIG source raises irq on the first crossing sample.
// R4 - each axis has its own enable; disabled axes never trigger.
// R5 - hold mode keeps the event flagged until the status register is read.
// R6 - without hold the interrupt follows the live event condition; an enabled IRQ_TRIG source keeps irq high until trig_r is cleared.
// R7 - without hold the status shows the most recent event only.
// R8 - count-down mode decrements the debounce counter when the condition drops.
// R9 - clear mode zeroes the debounce counter when the condition drops.
// R10 - configuration is writable only in standby; host switches modes around changes.
// R11 - counter advances per sample while condition holds; fires when above setting.
package tsd_pkg;
  localparam int SMP_W = 12;
  localparam int FLT_W = 14;
  localparam int REG_AW = 4;
  localparam int REG_DW = 8;
  localparam int HPF_SHIFT = 4;
  localparam int THR_SHIFT = 3;
  localparam int NAXIS = 3;

  localparam logic [REG_AW-1:0] ADDR_CTRL = 4'h0;
  localparam logic [REG_AW-1:0] ADDR_CFG = 4'h1;
  localparam logic [REG_AW-1:0] ADDR_THR = 4'h2;
  localparam logic [REG_AW-1:0] ADDR_DBNC = 4'h3;
  localparam logic [REG_AW-1:0] ADDR_EVT = 4'h4;
  localparam logic [REG_AW-1:0] ADDR_IRQ_STAT = 4'h5;
  localparam logic [REG_AW-1:0] ADDR_IRQ_CLR = 4'h6;
  localparam logic [REG_AW-1:0] ADDR_IRQ_EN = 4'h7;

  localparam int CTRL_ACTIVE = 0;
  localparam int CFG_BYPASS = 0;
  localparam int CFG_AXIS_LSB = 1;
  localparam int CFG_HOLD = 4;
  localparam int CFG_COUNT_DOWN = 5;
  localparam int CFG_W = 6;
  localparam int EVT_ACTIVE = 7;
  localparam int IRQ_EVT = 0;
  localparam int IRQ_TRIG = 1;
  localparam int IRQ_W = 2;

  localparam logic [CFG_W-1:0] CFG_RST = 6'h0e;
  localparam logic [REG_DW-1:0] THR_RST = 8'h10;
  localparam logic [REG_DW-1:0] DBNC_RST = 8'h04;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 2'h0;
  localparam logic [REG_DW-1:0] CNT_MAX = 8'hff;

  typedef enum logic {TSD_STANDBY, TSD_ACTIVE} tsd_mode_t;
endpackage

// file: dv/tsd_host.sv
// Purpose: host model that drives the register port of the shake detector
// Assumes: one strobe per access, read data in the cycle after the read strobe
// Notes: configuration changes are framed by standby and active
`timescale 1ns/1ps
module tsd_host (
  input wire logic clk_sys,
  output logic [tsd_pkg::REG_AW-1:0] reg_addr,
  output logic [tsd_pkg::REG_DW-1:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [tsd_pkg::REG_DW-1:0] reg_rdata
);
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    // return once the write has settled so callers see its effect
    @(negedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask
  // settings only land while in standby
  task automatic setup(input logic [7:0] cfg, input logic [7:0] dbnc);
    wr(tsd_pkg::ADDR_CTRL, 8'h00);
    wr(tsd_pkg::ADDR_CFG, cfg);
    wr(tsd_pkg::ADDR_DBNC, dbnc);
    wr(tsd_pkg::ADDR_CTRL, 8'h01);
  endtask
endmodule // tsd_host

// file: dv/transient_shake_detector_bench.sv
// Purpose: self-checking bench for the transient shake detector
// Assumes: threshold 0x10 scales to 128 counts
// Notes: y axis held at zero; x and z carry the stimulus
`timescale 1ns/1ps
module transient_shake_detector_bench;
  logic clk_sys, resetn, sample_valid, reg_wr, reg_rd, irq;
  logic signed [tsd_pkg::SMP_W-1:0] sample_x, sample_y, sample_z;
  logic [tsd_pkg::REG_AW-1:0] reg_addr;
  logic [tsd_pkg::REG_DW-1:0] reg_wdata, reg_rdata, rv;
  int error_cnt, checks, cyc;
  tsd_detector dut_u (.clk_sys(clk_sys), .resetn(resetn), .sample_valid(sample_valid), .sample_x(sample_x),
    .sample_y(sample_y), .sample_z(sample_z), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  tsd_host host_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rchk(string name, logic [3:0] a, logic [7:0] exp);
    host_u.rd(a, rv);
    check(name, rv, exp);
  endtask
  task automatic ci(logic exp);
    check("irq", {7'h00, irq}, {7'h00, exp});
  endtask
  task automatic smp(int n, logic signed [11:0] x, logic signed [11:0] z);
    repeat (n) begin
      @(posedge clk_sys);
      sample_valid <= 1'b1;
      sample_x <= x;
      sample_z <= z;
      @(posedge clk_sys);
      sample_valid <= 1'b0;
    end
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  // two good samples, one drop, two good samples
  task automatic pat();
    smp(2, 12'sd200, 12'sd0);
    smp(1, 12'sd0, 12'sd0);
    smp(2, 12'sd200, 12'sd0);
  endtask
  task automatic complete_run();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  initial begin
    resetn = 1'b0;
    sample_valid = 1'b0;
    sample_x = '0;
    sample_y = '0;
    sample_z = '0;
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    rchk("cfg", tsd_pkg::ADDR_CFG, 8'h0e);
    rchk("dbnc", tsd_pkg::ADDR_DBNC, 8'h04);
    host_u.wr(tsd_pkg::ADDR_IRQ_EN, 8'h01);
    host_u.wr(tsd_pkg::ADDR_CTRL, 8'h01);
    smp(5, 12'sd200, 12'sd0);
    ci(1'b1);
    smp(55, 12'sd200, 12'sd0);
    ci(1'b0);
    host_u.setup(8'h0f, 8'h04);
    smp(5, 12'sd200, 12'sd0);
    ci(1'b1);
    host_u.setup(8'h0f, 8'h02);
    smp(2, 12'sd200, 12'sd0);
    ci(1'b0);
    smp(1, -12'sd200, 12'sd0);
    ci(1'b1);
    rchk("evt", tsd_pkg::ADDR_EVT, 8'h81);
    smp(1, 12'sd0, 12'sd0);
    ci(1'b0);
    rchk("evt", tsd_pkg::ADDR_EVT, 8'h01);
    host_u.wr(tsd_pkg::ADDR_IRQ_CLR, 8'h02);
    smp(6, 12'sd127, -12'sd127);
    rchk("stat", tsd_pkg::ADDR_IRQ_STAT, 8'h00);
    smp(1, 12'sd128, 12'sd0);
    rchk("stat", tsd_pkg::ADDR_IRQ_STAT, 8'h02);
    ci(1'b0);
    host_u.wr(tsd_pkg::ADDR_IRQ_EN, 8'h03);
    ci(1'b1);
    host_u.wr(tsd_pkg::ADDR_IRQ_CLR, 8'h02);
    ci(1'b0);
    host_u.wr(tsd_pkg::ADDR_IRQ_EN, 8'h01);
    host_u.wr(tsd_pkg::ADDR_THR, 8'hff);
    rchk("thr", tsd_pkg::ADDR_THR, 8'h10);
    host_u.setup(8'h0d, 8'h02);
    smp(4, 12'sd200, 12'sd0);
    ci(1'b0);
    rchk("stat", tsd_pkg::ADDR_IRQ_STAT, 8'h00);
    smp(3, 12'sd0, 12'sd200);
    ci(1'b1);
    host_u.setup(8'h0f, 8'h02);
    pat();
    ci(1'b0);
    host_u.setup(8'h2f, 8'h02);
    pat();
    ci(1'b1);
    host_u.setup(8'h1f, 8'h02);
    smp(3, 12'sd200, 12'sd0);
    smp(1, 12'sd0, 12'sd0);
    ci(1'b1);
    rchk("evt", tsd_pkg::ADDR_EVT, 8'h81);
    ci(1'b0);
    rchk("unmapped", 4'h8, 8'h00);
    rchk("clr", tsd_pkg::ADDR_IRQ_CLR, 8'h00);
    smp(3, 12'sd200, 12'sd0);
    ci(1'b1);
    // reset in mid-run drops the held event and restores the settings
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    @(negedge clk_sys);
    ci(1'b0);
    rchk("ctrl", tsd_pkg::ADDR_CTRL, 8'h00);
    rchk("cfg", tsd_pkg::ADDR_CFG, 8'h0e);
    rchk("irq_en", tsd_pkg::ADDR_IRQ_EN, 8'h00);
    complete_run();
  end
endmodule // transient_shake_detector_bench
